// ---- rtl/gpp_top.sv ----
`default_nettype none

module gpp_top #(
  parameter int PORT_CNT = gpp_pkg::PORT_CNT,
  parameter int PORT_W   = gpp_pkg::PORT_W
) (
  // clock and reset
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   resetn_i,
  // nonvolatile default mode bit
  input  wire logic                                   default_io_mode_cfg_i,
  // mode control, write strobe with one code per pin
  input  wire logic                                   mode_we_i,
  input  wire logic [PORT_CNT*PORT_W-1:0][1:0]        mode_wdata_i,
  // output data, write strobe with per-bit mask
  input  wire logic                                   dout_we_i,
  input  wire logic [PORT_CNT*PORT_W-1:0]             dout_wmask_i,
  input  wire logic [PORT_CNT*PORT_W-1:0]             dout_wdata_i,
  // per-port function select words
  input  wire logic [PORT_CNT-1:0][31:0]              pin_function_select_i,
  // interrupt setup and clear
  input  wire gpp_pkg::gpp_pin_cfg_s [PORT_CNT*PORT_W-1:0] pin_cfg_i,
  input  wire logic [PORT_CNT*PORT_W-1:0]             irq_clr_i,
  // pads
  input  wire logic [PORT_CNT*PORT_W-1:0]             pin_i,
  output logic      [PORT_CNT*PORT_W-1:0]             pin_o,
  output logic      [PORT_CNT*PORT_W-1:0]             pin_oe_o,
  output logic      [PORT_CNT*PORT_W-1:0]             pull_up_o,
  output logic      [PORT_CNT*PORT_W-1:0]             schmitt_o,
  // readback
  output logic      [PORT_CNT*PORT_W-1:0][1:0]        pin_mode_o,
  output logic      [PORT_CNT*PORT_W-1:0]             port_output_data_o,
  output logic      [PORT_CNT*PORT_W-1:0]             pin_val_o,
  output logic      [PORT_CNT*PORT_W-1:0]             irq_status_o,
  // interrupt lines
  output logic                                        ext_irq_line_a_o,
  output logic                                        ext_irq_line_b_o,
  output logic                                        port_group_low_irq_o,
  output logic                                        port_group_mid_irq_o,
  output logic                                        port_group_high_irq_o,
  output logic                                        wake_o
);

  localparam int SLOTS = PORT_CNT * PORT_W;

  typedef struct packed {
    logic [SLOTS-1:0][1:0] mode;
    logic [SLOTS-1:0]      dout;
    logic                  init;
    logic                  line_a;
    logic                  line_b;
    logic                  grp_low;
    logic                  grp_mid;
    logic                  grp_high;
    logic                  wake;
  } gpp_top_st_s;

  gpp_top_st_s           q;
  gpp_top_st_s           next_q;
  logic [SLOTS-1:0]      flag;
  logic [SLOTS-1:0]      live;
  logic [SLOTS-1:0][1:0] mode_dflt;
  logic [SLOTS-1:0][1:0] mode_new;
  logic [SLOTS-1:0]      dout_new;
  logic [SLOTS-1:0]      low_hit;
  logic [SLOTS-1:0]      mid_hit;
  logic [SLOTS-1:0]      high_hit;

  // ----------------------------------------------------------------
  // per-slot next mode and next data
  // ----------------------------------------------------------------
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    if (gpp_pkg::PIN_PRESENT[s]) begin : g_live
      // mode every pin takes once reset lets go
      assign mode_dflt[s] = (default_io_mode_cfg_i == gpp_pkg::CFG_QUASI) ?
                            gpp_pkg::MODE_QUASI : gpp_pkg::MODE_INPUT;
      // the default load shuts out a write on the same edge
      assign mode_new[s]  = q.init    ? mode_dflt[s]    :
                            mode_we_i ? mode_wdata_i[s] : q.mode[s];
    end else begin : g_dead
      // absent slot stays an input for good
      assign mode_dflt[s] = gpp_pkg::MODE_INPUT;
      assign mode_new[s]  = gpp_pkg::MODE_INPUT;
    end
    // masked data write, one bit per slot
    assign dout_new[s] = (dout_we_i & dout_wmask_i[s]) ? dout_wdata_i[s] : q.dout[s];
  end

  // ----------------------------------------------------------------
  // interrupt routing words, absent slots never reach a line
  // ----------------------------------------------------------------
  assign live     = flag & SLOTS'(gpp_pkg::PIN_PRESENT);
  assign low_hit  = live & SLOTS'(gpp_pkg::GRP_LOW_MASK);
  assign mid_hit  = live & SLOTS'(gpp_pkg::GRP_MID_MASK);
  assign high_hit = live & SLOTS'(gpp_pkg::GRP_HI_MASK);

  // ----------------------------------------------------------------
  // next state: modes, data, interrupt lines
  // ----------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.init     = 1'b0;
    // mode and data words come from the slot loop
    next_q.mode     = mode_new;
    next_q.dout     = dout_new;
    // lines and wake register one cycle behind the flags
    next_q.line_a   = live[gpp_pkg::IDX_EXT_A];
    next_q.line_b   = live[gpp_pkg::IDX_EXT_B];
    next_q.grp_low  = |low_hit;
    next_q.grp_mid  = |mid_hit;
    next_q.grp_high = |high_hit;
    next_q.wake     = |live;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q.mode     <= {SLOTS{gpp_pkg::MODE_INPUT}};
      q.dout     <= SLOTS'(gpp_pkg::DOUT_RESET);
      q.init     <= 1'b1;
      q.line_a   <= 1'b0;
      q.line_b   <= 1'b0;
      q.grp_low  <= 1'b0;
      q.grp_mid  <= 1'b0;
      q.grp_high <= 1'b0;
      q.wake     <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // per-pin logic, only for implemented slots
  // ----------------------------------------------------------------
  for (genvar g = 0; g < SLOTS; g++) begin : g_pin
    if (gpp_pkg::PIN_PRESENT[g]) begin : g_on
      gpp_pkg::gpp_pad_s pad;
      // independent cell per pin
      gpp_pin u_pin (
        .sys_clk_i     (sys_clk_i),
        .resetn_i      (resetn_i),
        .pin_i         (pin_i[g]),
        .pad_o         (pad),
        .mode_i        (q.mode[g]),
        .dout_i        (q.dout[g]),
        .schmitt_sel_i (pin_function_select_i[g / PORT_W]
                          [gpp_pkg::SCHMITT_LSB + (g % PORT_W)]),
        .cfg_i         (pin_cfg_i[g]),
        .clr_i         (irq_clr_i[g]),
        .pin_val_o     (pin_val_o[g]),
        .irq_o         (flag[g])
      );
      assign pin_o[g]     = pad.out;
      assign pin_oe_o[g]  = pad.oe;
      assign pull_up_o[g] = pad.pull_up;
      assign schmitt_o[g] = pad.schmitt;
    end else begin : g_off
      // absent slot stays released and quiet
      assign pin_o[g]     = 1'b0;
      assign pin_oe_o[g]  = 1'b0;
      assign pull_up_o[g] = 1'b0;
      assign schmitt_o[g] = 1'b0;
      assign pin_val_o[g] = 1'b0;
      assign flag[g]      = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pin_mode_o            = q.mode;
  assign port_output_data_o    = q.dout;
  assign irq_status_o          = flag;
  assign ext_irq_line_a_o      = q.line_a;
  assign ext_irq_line_b_o      = q.line_b;
  assign port_group_low_irq_o  = q.grp_low;
  assign port_group_mid_irq_o  = q.grp_mid;
  assign port_group_high_irq_o = q.grp_high;
  assign wake_o                = q.wake;

endmodule : gpp_top

`default_nettype wire

// ---- rtl/gpp_pkg.sv ----
// Operation
// - 33 pins in six ports, each pin with own mode and data bits.
// - each pin selectable as input, push-pull, open-drain or quasi-bidirectional.
// - during chip reset all pins are inputs and all output data bits are one.
// - a configuration bit picks default mode: 0 quasi-bidirectional, 1 input tri-state.
// - quasi pins pick TTL or Schmitt input through bits 23:16 of function select.
// - weak pull-up enabled only while the pin is quasi-bidirectional.
// - each pin may raise an interrupt, edge or level sensitive.
// - an enabled pin interrupt also acts as a wake-up source.
// - pin 3.2 and 5.2 own lines; groups ports 0-1, 2-4, 5; all wake.
`default_nettype none

package gpp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PORT_CNT = 6;
  localparam int PORT_W   = 8;
  localparam int SLOTS    = PORT_CNT * PORT_W;

  // implemented pins, one bit per port slot, 33 in all
  localparam logic [47:0] PIN_PRESENT = 48'h0F_C0_7F_FC_3F_FF;

  // ----------------------------------------------------------------
  // pin modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_PUSH  = 2'h1;
  localparam logic [1:0] MODE_OPEN  = 2'h2;
  localparam logic [1:0] MODE_QUASI = 2'h3;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [47:0] DOUT_RESET   = 48'hFFFF_FFFF_FFFF;
  localparam logic        PIN_IDLE     = 1'h1;
  localparam logic        CFG_QUASI    = 1'h0;
  localparam int          SCHMITT_LSB  = 16;
  localparam int          SCHMITT_MSB  = 23;

  // ----------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------
  localparam int          IDX_EXT_A    = 26;
  localparam int          IDX_EXT_B    = 42;
  localparam logic [47:0] GRP_LOW_MASK = 48'h00_00_00_00_FF_FF;
  localparam logic [47:0] GRP_MID_MASK = 48'h00_FF_FB_FF_00_00;
  localparam logic [47:0] GRP_HI_MASK  = 48'hFB_00_00_00_00_00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_en;
    logic irq_level;
    logic irq_high;
  } gpp_pin_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic schmitt;
  } gpp_pad_s;

endpackage : gpp_pkg

`default_nettype wire

// ---- rtl/gpp_pin.sv ----
`default_nettype none

module gpp_pin (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // pad side
  input  wire logic              pin_i,
  output gpp_pkg::gpp_pad_s      pad_o,
  // control
  input  wire logic [1:0]        mode_i,
  input  wire logic              dout_i,
  input  wire logic              schmitt_sel_i,
  input  wire gpp_pkg::gpp_pin_cfg_s cfg_i,
  input  wire logic              clr_i,
  // status
  output logic                   pin_val_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic [2:0]        sync;
    logic              val;
    logic              flag;
    gpp_pkg::gpp_pad_s pad;
  } gpp_pin_st_s;

  gpp_pin_st_s q;
  gpp_pin_st_s next_q;
  logic        rise;
  logic        fall;
  logic        hit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q      = q;
    next_q.sync = {q.sync[1:0], pin_i};
    // change taken once second and third stage agree
    if (q.sync[1] == q.sync[2]) begin
      next_q.val = q.sync[2];
    end
    rise = next_q.val & ~q.val;
    fall = ~next_q.val & q.val;
    hit  = cfg_i.irq_high ? rise : fall;
    // interrupt detect, a new edge beats a clear
    if (!cfg_i.irq_en) begin
      next_q.flag = 1'b0;
    end else if (cfg_i.irq_level) begin
      next_q.flag = (q.val == cfg_i.irq_high);
    end else begin
      next_q.flag = hit | (q.flag & ~clr_i);
    end
    // pad drive per mode
    unique case (mode_i)
      gpp_pkg::MODE_INPUT: begin
        next_q.pad.out = 1'b0;
        next_q.pad.oe  = 1'b0;
      end
      gpp_pkg::MODE_PUSH: begin
        next_q.pad.out = dout_i;
        next_q.pad.oe  = 1'b1;
      end
      gpp_pkg::MODE_OPEN, gpp_pkg::MODE_QUASI: begin
        next_q.pad.out = 1'b0;
        next_q.pad.oe  = ~dout_i;
      end
    endcase
    next_q.pad.pull_up = (mode_i == gpp_pkg::MODE_QUASI);
    next_q.pad.schmitt = (mode_i == gpp_pkg::MODE_QUASI) & schmitt_sel_i;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q.sync        <= {3{gpp_pkg::PIN_IDLE}};
      q.val         <= gpp_pkg::PIN_IDLE;
      q.flag        <= 1'b0;
      q.pad.out     <= 1'b0;
      q.pad.oe      <= 1'b0;
      q.pad.pull_up <= 1'b0;
      q.pad.schmitt <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign pad_o     = q.pad;
  assign pin_val_o = q.val;
  assign irq_o     = q.flag;

endmodule : gpp_pin

`default_nettype wire

// ---- sim/gpp_top_asserts.sv ----
`default_nettype none

module gpp_top_asserts #(
  parameter int PORT_CNT = 6,
  parameter int PORT_W   = 8
) (
  // clock and reset
  input wire logic                              sys_clk_i,
  input wire logic                              resetn_i,
  // controls
  input wire logic                              default_io_mode_cfg_i,
  input wire logic                              mode_we_i,
  input wire logic [PORT_CNT*PORT_W-1:0][1:0]   mode_wdata_i,
  input wire logic                              dout_we_i,
  input wire logic [PORT_CNT*PORT_W-1:0]        dout_wmask_i,
  input wire logic [PORT_CNT*PORT_W-1:0]        dout_wdata_i,
  // observed outputs
  input wire logic [PORT_CNT*PORT_W-1:0]        pin_o,
  input wire logic [PORT_CNT*PORT_W-1:0]        pin_oe_o,
  input wire logic [PORT_CNT*PORT_W-1:0]        pull_up_o,
  input wire logic [PORT_CNT*PORT_W-1:0][1:0]   pin_mode_o,
  input wire logic [PORT_CNT*PORT_W-1:0]        port_output_data_o,
  input wire logic [PORT_CNT*PORT_W-1:0]        irq_status_o,
  input wire logic                              ext_irq_line_a_o,
  input wire logic                              port_group_mid_irq_o,
  input wire logic                              wake_o
);
  localparam int N = PORT_CNT * PORT_W;
  logic [N-1:0]      qv, pv, dv, pr;
  logic [N-1:0][1:0] mexp, dexp;
  // per-slot mode decode and expected mode vectors
  always_comb begin
    pr = gpp_pkg::PIN_PRESENT;
    for (int g = 0; g < N; g++) begin
      qv[g]   = pin_mode_o[g] == gpp_pkg::MODE_QUASI;
      pv[g]   = pin_mode_o[g] == gpp_pkg::MODE_PUSH;
      dv[g]   = pin_mode_o[g] == gpp_pkg::MODE_OPEN;
      mexp[g] = pr[g] ? mode_wdata_i[g] : 2'h0;
      dexp[g] = (pr[g] && !default_io_mode_cfg_i) ? gpp_pkg::MODE_QUASI : 2'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  mode_wr_a: assert property (mode_we_i && $past(resetn_i) |=> pin_mode_o == $past(mexp))
    else $error("mode write not applied");
  dflt_mode_a: assert property ($rose(resetn_i) |=> pin_mode_o == $past(dexp))
    else $error("default mode not loaded");
  dout_wr_a: assert property (dout_we_i |=> port_output_data_o ==
    (($past(port_output_data_o) & ~$past(dout_wmask_i))
    | $past(dout_wdata_i & dout_wmask_i)))
    else $error("masked data write wrong");
  dout_hold_a: assert property (!dout_we_i |=> $stable(port_output_data_o))
    else $error("output data changed without write");
  pull_up_a: assert property (pull_up_o == $past(qv))
    else $error("pull-up not tied to quasi mode");
  drive_en_a: assert property (pin_oe_o == $past(pv | ((qv | dv) & ~port_output_data_o)))
    else $error("output enable wrong");
  drive_val_a: assert property (pin_o == $past(pv & port_output_data_o))
    else $error("driven value wrong");
  line_a_a: assert property (ext_irq_line_a_o == $past(irq_status_o[gpp_pkg::IDX_EXT_A]))
    else $error("dedicated line does not follow flag");
  grp_mid_a: assert property (port_group_mid_irq_o ==
    $past(|(irq_status_o & gpp_pkg::GRP_MID_MASK)))
    else $error("middle group line wrong");
  wake_a: assert property (wake_o == $past(|irq_status_o))
    else $error("wake does not follow flags");
endmodule : gpp_top_asserts

bind gpp_top gpp_top_asserts #(.PORT_CNT(PORT_CNT), .PORT_W(PORT_W)) u_gpp_top_asserts (
  .sys_clk_i, .resetn_i, .default_io_mode_cfg_i, .mode_we_i, .mode_wdata_i, .dout_we_i,
  .dout_wmask_i, .dout_wdata_i, .pin_o, .pin_oe_o, .pull_up_o, .pin_mode_o,
  .port_output_data_o, .irq_status_o, .ext_irq_line_a_o, .port_group_mid_irq_o, .wake_o);

`default_nettype wire

// ---- sim/gpp_board.sv ----
`default_nettype none

module gpp_board (
  // clock
  input  wire logic        sys_clk_i,
  // device pad side
  input  wire logic [47:0] pin_o,
  input  wire logic [47:0] pin_oe_o,
  input  wire logic [47:0] pull_up_o,
  // external drivers
  input  wire logic [47:0] ext_en_i,
  input  wire logic [47:0] ext_val_i,
  output logic      [47:0] pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] flt = 48'hAAAA_AAAA_AAAA;
  // undriven lines wander so a stale level never reads back
  always @(posedge sys_clk_i) flt <= ~flt;
  // wired level: any low driver wins, then high driver or pull-up
  assign pin_i = ~((pin_oe_o & ~pin_o) | (ext_en_i & ~ext_val_i)) & ((pin_oe_o & pin_o)
                 | (ext_en_i & ext_val_i) | pull_up_o | (~(pin_oe_o | ext_en_i) & flt));
endmodule : gpp_board

`default_nettype wire

// ---- sim/tb_gpp_top.sv ----
`default_nettype none

module tb_gpp_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, default_io_mode_cfg_i = 1'b1;
  logic mode_we_i = 1'b0, dout_we_i = 1'b0;
  logic [47:0][1:0] mode_wdata_i = '0, pin_mode_o;
  logic [47:0] dout_wmask_i = '0, dout_wdata_i = '0, irq_clr_i = '0, ext_en = '0, ext_val = '0;
  logic [47:0] pin_i, pin_o, pin_oe_o, pull_up_o, schmitt_o, port_output_data_o, pin_val_o;
  logic [47:0] irq_status_o, pr = gpp_pkg::PIN_PRESENT;
  logic [5:0][31:0] pin_function_select_i = '0;
  gpp_pkg::gpp_pin_cfg_s [47:0] pin_cfg_i = '0;
  logic ext_irq_line_a_o, ext_irq_line_b_o, port_group_low_irq_o, port_group_mid_irq_o;
  logic port_group_high_irq_o, wake_o;
  int fail_count = 0, checks_done = 0;

  gpp_top u_gpp_top (.sys_clk_i, .resetn_i, .default_io_mode_cfg_i, .mode_we_i, .mode_wdata_i,
    .dout_we_i, .dout_wmask_i, .dout_wdata_i, .pin_function_select_i, .pin_cfg_i, .irq_clr_i,
    .pin_i, .pin_o, .pin_oe_o, .pull_up_o, .schmitt_o, .pin_mode_o, .port_output_data_o,
    .pin_val_o, .irq_status_o, .ext_irq_line_a_o, .ext_irq_line_b_o, .port_group_low_irq_o,
    .port_group_mid_irq_o, .port_group_high_irq_o, .wake_o);
  gpp_board u_gpp_board (.sys_clk_i, .pin_o, .pin_oe_o, .pull_up_o, .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_i);

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string what, input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset state, then default mode load with the given config
  task automatic t_reset(input logic c);
    logic [47:0][1:0] m;
    resetn_i = 1'b0;
    default_io_mode_cfg_i = c;
    tick(20);
    chk("mode in reset", pin_mode_o, '0);
    chk("data in reset", port_output_data_o & pr, pr);
    resetn_i = 1'b1;
    tick(3);
    for (int g = 0; g < 48; g++) m[g] = (pr[g] && !c) ? gpp_pkg::MODE_QUASI : 2'h0;
    chk("default mode", pin_mode_o, m);
    chk("default pull", pull_up_o, c ? 48'h0 : pr);
  endtask : t_reset

  // mixed per-pin modes rotated through every code, masked data write
  task automatic t_drive();
    logic [47:0][1:0] m;
    logic [47:0] d, eo, ev, ep, es;
    d = 48'h96C3_5A0F_F0A5;
    for (int p = 0; p < 6; p++) pin_function_select_i[p] = 32'h00A5_0000 ^ (p << 16);
    dout_wmask_i = '1;
    dout_wdata_i = d;
    dout_we_i = 1'b1;
    tick(1);
    dout_wmask_i = 48'h00FF_FF00_0000;
    dout_wdata_i = '0;
    tick(1);
    dout_we_i = 1'b0;
    d = d & ~48'h00FF_FF00_0000;
    tick(1);
    chk("output data", port_output_data_o, d);
    for (int k = 0; k < 4; k++) begin
      for (int g = 0; g < 48; g++) begin
        m[g] = pr[g] ? 2'((g + k) % 4) : 2'h0;
        ep[g] = m[g] == gpp_pkg::MODE_QUASI;
        ev[g] = m[g] == gpp_pkg::MODE_PUSH && d[g];
        eo[g] = m[g] == gpp_pkg::MODE_PUSH || ((ep[g] || m[g] == gpp_pkg::MODE_OPEN) && !d[g]);
        es[g] = ep[g] && pin_function_select_i[g / 8][16 + g % 8];
      end
      mode_wdata_i = m;
      mode_we_i = 1'b1;
      tick(1);
      mode_we_i = 1'b0;
      tick(2);
      chk("mode readback", pin_mode_o, m);
      chk("drive enable", pin_oe_o, eo);
      chk("drive value", pin_o, ev);
      chk("pull-up", pull_up_o, ep);
      chk("schmitt", schmitt_o, es);
    end
  endtask : t_drive

  // rising edge on one pin per line, then a low level interrupt
  task automatic t_irq();
    int sl[5] = '{26, 42, 0, 18, 40};
    mode_wdata_i = '0;
    mode_we_i = 1'b1;
    ext_en = pr;
    ext_val = '0;
    tick(1);
    mode_we_i = 1'b0;
    foreach (sl[i]) pin_cfg_i[sl[i]] = '{irq_en: 1'b1, irq_level: 1'b0, irq_high: 1'b1};
    tick(6);
    foreach (sl[i]) begin
      ext_val[sl[i]] = 1'b1;
      tick(7);
      chk("flags", irq_status_o, 48'h1 << sl[i]);
      chk("pin value", pin_val_o, ext_val & pr);
      chk("lines", {ext_irq_line_a_o, ext_irq_line_b_o, port_group_low_irq_o,
        port_group_mid_irq_o, port_group_high_irq_o, wake_o}, {5'h10 >> i, 1'b1});
      irq_clr_i[sl[i]] = 1'b1;
      tick(1);
      irq_clr_i = '0;
      tick(3);
      chk("wake cleared", {irq_status_o, wake_o}, '0);
    end
    pin_cfg_i[0] = '{irq_en: 1'b1, irq_level: 1'b1, irq_high: 1'b0};
    ext_val[0] = 1'b0;
    tick(7);
    irq_clr_i[0] = 1'b1;
    tick(1);
    irq_clr_i = '0;
    tick(2);
    chk("level flag", {irq_status_o, port_group_low_irq_o}, {48'h1, 1'b1});
    ext_val[0] = 1'b1;
    tick(7);
    chk("level gone", irq_status_o, '0);
    chk("pin value high", pin_val_o, ext_val & pr);
    // falling edge meeting a clear in its own cycle, the set must win
    pin_cfg_i[0] = '{irq_en: 1'b1, irq_level: 1'b0, irq_high: 1'b0};
    ext_val[0] = 1'b0;
    tick(3);
    irq_clr_i[0] = 1'b1;
    tick(1);
    irq_clr_i = '0;
    tick(2);
    chk("set beats clear", {irq_status_o, port_group_low_irq_o}, {48'h1, 1'b1});
  endtask : t_irq

  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_drive();
    t_irq();
    test_done();
  end

  // watchdog far beyond the roughly 150 cycles the run needs
  initial begin
    #100us;
    fail_count++;
    test_done();
  end
endmodule : tb_gpp_top

`default_nettype wire
